// File: common/wdog_pkg.sv
// package: timing constants for the watchdog and supply supervisor
// assumes a 50 MHz system clock
package wdog_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  // watchdog deadline in milliseconds (1.5 s)
  localparam int unsigned TIMEOUT_MS      = 1500;
  // reset pulse length in milliseconds
  localparam int unsigned PULSE_MS        = 50;
  localparam int unsigned TIMEOUT_CYCLES  = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned PULSE_CYCLES    = (CLK_HZ / 1000) * PULSE_MS;
  // supply threshold in millivolts, judged by the external comparator
  localparam int unsigned SUPPLY_GOOD_MV  = 4500;
  localparam int unsigned SYNC_STAGES     = 3;
endpackage

// File: common/sync_if.sv
// interface: one synchronised pin level with its agreed value and edge strobe
// assumes the producer and consumer share sys_clk
`timescale 1ns/100ps
interface sync_if;
  logic level;  // agreed, stable level
  logic edge_p; // one-cycle pulse on any agreed change
  modport src (output level, output edge_p);
  modport dst (input level, input edge_p);
endinterface

// File: rtl/pin_sync.sv
// three-flop pin synchroniser; a change counts once stages two and three agree
// assumes an asynchronous input pin and sys_clk
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic sys_rst,  // synchronous reset
  input  wire logic pin,      // raw asynchronous pin
  sync_if.src       out       // agreed level and change pulse
);
  logic [2:0] stage_q;
  logic       level_q;
  logic       edge_q;

  // shift chain; stage 0 feeds only stage 1
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage_q <= {3{RESET_VAL}};
    end else begin
      stage_q <= {stage_q[1:0], pin};
    end
  end

  // accept a new level only when the two late stages agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level_q <= RESET_VAL;
      edge_q  <= 1'b0;
    end else begin
      edge_q <= 1'b0;
      if (stage_q[1] == stage_q[2] && stage_q[2] != level_q) begin
        level_q <= stage_q[2];
        edge_q  <= 1'b1;
      end
    end
  end

  assign out.level  = level_q;
  assign out.edge_p = edge_q;
endmodule

// File: rtl/wdog_supervisor.sv
// watchdog plus supply supervisor: timeout reset, power-fail reset, write block
// the watchdog and reset line share one supervisor state machine; the write gate uses the synced supply fault alone
// assumes sys_rst comes only from power-on; pins are asynchronous
// assumes an external comparator reports supply level on supply_good
// assumes the write strobe input is already on sys_clk
// timeout and pulse lengths are parameters so short runs stay practical
`timescale 1ns/100ps
// Notes on behaviour
// - missed deadline gives 50 ms reset pulse
// - each toggle restarts the full interval
// - disable input suppresses watchdog resets
// - every reset also wakes the processor
// - supply fault forces system reset
// - hold reset until supply reaches 4.5 V
// - supply fault blocks memory write strobe
module wdog_supervisor #(
  parameter int unsigned TIMEOUT_CYC = wdog_pkg::TIMEOUT_CYCLES,
  parameter int unsigned PULSE_CYC   = wdog_pkg::PULSE_CYCLES
) (
  input  wire logic sys_clk,     // 50 MHz system clock
  input  wire logic sys_rst,     // power-on reset, sync, high
  input  wire logic wd_toggle,   // watchdog kick pin from host
  input  wire logic wd_disable,  // static strap, high disables watchdog
  input  wire logic supply_good, // comparator: vcc at or above 4.5 V
  input  wire logic mem_wr_n_in, // processor write strobe, low active
  output logic      sys_reset,   // system reset to processor, high
  output logic      wake,        // wake release for stop/halt
  output logic      mem_wr_n,    // gated write strobe, low active
  output logic      wd_fired     // pulse: watchdog timeout seen
);
  typedef enum logic [1:0] {ST_POWER, ST_RUN, ST_PULSE} state_e;

  // supply judged bad when the synced comparator level is low
  function automatic logic supply_bad(input logic good_lvl);
    supply_bad = !good_lvl;
  endfunction

  // watchdog may fire only when running, enabled and supply good
  function automatic logic wd_armed(
    input state_e st,       // present supervisor state
    input logic   dis_lvl,  // synced disable strap
    input logic   good_lvl  // synced supply level
  );
    wd_armed = (st == ST_RUN) && !dis_lvl && !supply_bad(good_lvl);
  endfunction

  // counter end test, shared by the deadline and pulse counters
  function automatic logic count_done(
    input logic [31:0] cnt,   // running count
    input int unsigned limit  // cycles in the interval
  );
    count_done = (cnt >= limit - 1);
  endfunction

  sync_if tog_s ();
  sync_if dis_s ();
  sync_if pg_s ();

  // kick pin; either agreed change is a retrigger
  pin_sync #(.RESET_VAL(1'b0)) u_tog (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     (wd_toggle),
    .out     (tog_s)
  );
  // disable strap resets as disabled, so nothing fires before it is known
  pin_sync #(.RESET_VAL(1'b1)) u_dis (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     (wd_disable),
    .out     (dis_s)
  );
  // supply level resets as bad, so reset holds until it is known
  pin_sync #(.RESET_VAL(1'b0)) u_pg (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     (supply_good),
    .out     (pg_s)
  );

  // state and counters
  state_e      state_q;
  logic [31:0] wd_cnt_q;
  logic [31:0] pulse_cnt_q;

  // registered outputs
  logic        fired_q;
  logic        rst_q;
  logic        wr_n_q;

  // decoded conditions
  logic        timeout;     // watchdog count at its last value
  logic        pulse_done;  // last cycle of the reset pulse
  logic        fault;       // synced supply out of tolerance
  logic        wd_restart;  // any cause that zeroes the watchdog count
  logic        go_power;    // supply lost: back to power hold
  logic        go_pulse;    // deadline missed while armed
  logic        go_run;      // hold or pulse finished

  // shared compare; both counters start at zero, so limit minus one ends them
  assign timeout    = count_done(wd_cnt_q, TIMEOUT_CYC);
  assign pulse_done = count_done(pulse_cnt_q, PULSE_CYC);

  // synced supply fault, shared by reset, state and write gate
  assign fault = supply_bad(pg_s.level);

  // transition causes, kept apart so the case below reads as a table
  assign go_power = fault;
  assign go_pulse = wd_armed(state_q, dis_s.level, pg_s.level) && timeout;
  assign go_run   = (state_q == ST_POWER) ? !fault : pulse_done;

  // supervisor sequencing; a fault outranks every other cause
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_POWER;
    end else begin
      unique case (state_q)
        ST_POWER: begin
          // hold reset until the synced supply reads good
          if (go_run) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          // a fault outranks a missed deadline
          if (go_power) begin
            state_q <= ST_POWER;
          end else if (go_pulse) begin
            state_q <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          // a fault mid-pulse falls back to the power hold
          if (go_power) begin
            state_q <= ST_POWER;
          end else if (go_run) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          // unused code; recover through the power hold
          state_q <= ST_POWER;
        end
      endcase
    end
  end

  // restart causes; a re-enabled watchdog always begins a full interval
  always_comb begin
    // no cause: keep counting
    wd_restart = 1'b0;
    if (state_q != ST_RUN) begin
      wd_restart = 1'b1;
    end
    if (tog_s.edge_p) begin
      wd_restart = 1'b1;
    end
    if (dis_s.level) begin
      wd_restart = 1'b1;
    end
  end

  // watchdog counter; stops at the end value until the state moves on
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wd_cnt_q <= 32'h0000_0000;
    end else if (wd_restart) begin
      wd_cnt_q <= 32'h0000_0000;
    end else if (!timeout) begin
      wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
    end
  end

  // reset pulse width counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pulse_cnt_q <= 32'h0000_0000;
    end else if (state_q == ST_PULSE) begin
      // zero on the first pulse cycle, so the pulse lasts the full count
      pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
    end else begin
      pulse_cnt_q <= 32'h0000_0000;
    end
  end

  // reset line; high in any state but run, or at once on a fault
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= (state_q != ST_RUN) || fault;
    end
  end

  // timeout strobe; one cycle, raised with the move into the pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fired_q <= 1'b0;
    end else begin
      fired_q <= go_pulse;
    end
  end

  // write gate; raw strobe passes a flop so data stays registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_n_q <= 1'b1;
    end else begin
      wr_n_q <= mem_wr_n_in | fault;
    end
  end

  // reset doubles as the wake release for stop and halt
  assign sys_reset = rst_q;
  assign wake      = rst_q;
  // combinational force too, so a fault blocks writes with no lag
  assign mem_wr_n  = wr_n_q | fault;
  // strobe straight from its flop
  assign wd_fired  = fired_q;
endmodule

// File: verif/host_kicker.sv
// host model: flips the kick pin every gap+1 cycles while run is high
// assumes bench-driven run and gap on sys_clk
`timescale 1ns/100ps
module host_kicker (
  input  wire logic        sys_clk,  // clock
  input  wire logic        sys_rst,  // reset
  input  wire logic        run,      // host alive
  input  wire logic [15:0] gap,      // kick period in cycles, less one
  output logic             wd_toggle // kick pin
);
  logic [15:0] cnt_q;
  // a stalled host simply stops flipping the pin
  always_ff @(posedge sys_clk) begin
    cnt_q <= (sys_rst || !run || cnt_q == gap) ? 16'h0000 : cnt_q + 16'h0001;
    if (sys_rst) wd_toggle <= 1'b0;
    else if (run && cnt_q == gap) wd_toggle <= ~wd_toggle;
  end
endmodule

// File: verif/wdog_checker.sv
// checker: port relations of the watchdog supervisor
// assumes supply stays good while a watchdog pulse runs
`timescale 1ns/100ps
module wdog_checker #(
  parameter int unsigned TIMEOUT_CYC = 200,
  parameter int unsigned PULSE_CYC   = 20
) (
  input wire logic sys_clk,     // clock
  input wire logic sys_rst,     // reset
  input wire logic wd_toggle,   // kick pin
  input wire logic wd_disable,  // strap
  input wire logic supply_good, // supply ok
  input wire logic mem_wr_n_in, // strobe in
  input wire logic sys_reset,   // reset out
  input wire logic wake,        // wake out
  input wire logic mem_wr_n,    // strobe out
  input wire logic wd_fired     // timeout pulse
);
  localparam int LO = PULSE_CYC - 1;
  localparam int HI = PULSE_CYC + 3;
  int unsigned idle_q;
  logic        tog_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // cycles since last kick or reset; sync lag allowed for below
  always_ff @(posedge sys_clk) begin
    tog_q  <= wd_toggle;
    idle_q <= (sys_rst || sys_reset || wd_toggle != tog_q) ? '0 : idle_q + 1;
  end
  sequence s_held; sys_reset [*8]; endsequence
  sequence s_bad; !supply_good [*4]; endsequence
  property p_wake; wake == sys_reset; endproperty
  property p_fire; wd_fired |=> s_held; endproperty
  property p_len; wd_fired |-> ##[LO:HI] !sys_reset; endproperty
  property p_early; wd_fired |-> idle_q >= TIMEOUT_CYC - 2; endproperty
  property p_dis; wd_disable [*6] |-> !wd_fired; endproperty
  property p_flt; !supply_good [*6] |-> sys_reset; endproperty
  property p_wr; !supply_good [*6] |-> mem_wr_n; endproperty
  property p_hold; s_bad ##1 supply_good |-> sys_reset [*2]; endproperty
  a_wake: assert property (p_wake) else $error("wake off");
  a_fire: assert property (p_fire) else $error("pulse short");
  a_len: assert property (p_len) else $error("pulse long");
  a_early: assert property (p_early) else $error("early fire");
  a_dis: assert property (p_dis) else $error("fired disabled");
  a_flt: assert property (p_flt) else $error("no fault reset");
  a_wr: assert property (p_wr) else $error("write open");
  a_hold: assert property (p_hold) else $error("early release");
endmodule

// File: verif/test_wdog_supervisor.sv
// testbench: watchdog supervisor with shortened timeout and pulse
// assumes host model and checker from verif
`timescale 1ns/100ps
module test_wdog_supervisor;
  localparam int TO = 200;
  localparam int PL = 20;
  logic sys_clk = 1'b0, sys_rst = 1'b1, wd_disable = 1'b0, supply_good = 1'b0;
  logic mem_wr_n_in = 1'b0, run = 1'b0, wd_toggle, sys_reset, wake, mem_wr_n, wd_fired;
  int   err_count = 0, n_checks = 0, n;
  always #10 sys_clk = ~sys_clk;
  host_kicker i_host_kicker (.sys_clk, .sys_rst, .run, .gap(16'h0064), .wd_toggle);
  wdog_supervisor #(.TIMEOUT_CYC(TO), .PULSE_CYC(PL)) i_wdog_supervisor (.sys_clk, .sys_rst,
    .wd_toggle, .wd_disable, .supply_good, .mem_wr_n_in, .sys_reset, .wake, .mem_wr_n, .wd_fired);
  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // inputs always move 2 ns after an edge
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  task automatic wait_fire(output int c);
    for (c = 0; c < 3 * TO && wd_fired !== 1'b1; c++) cyc(1);
    if (c == 3 * TO) begin
      err_count++;
      test_done();
    end
    cyc(1);
  endtask
  task automatic pulse(output int c);
    for (c = 0; c < 4 * PL && sys_reset === 1'b1; c++) cyc(1);
  endtask
  task automatic t_main;
    cyc(10);
    chk(sys_reset, 1'b1);
    chk(mem_wr_n, 1'b1);
    supply_good = 1'b1;
    run = 1'b1;
    cyc(3);
    chk(sys_reset, 1'b1);
    cyc(8);
    chk(mem_wr_n, 1'b0);
    repeat (5 * TO) begin
      cyc(1);
      chk(sys_reset, 1'b0);
    end
    $display("kick done");
    run = 1'b0;
    wait_fire(n);
    chk(wake, 1'b1);
    pulse(n);
    chk(n >= PL - 1 && n <= PL + 3, 1'b1);
    wait_fire(n);
    chk(n >= TO - 1 && n <= TO + 4, 1'b1);
    pulse(n);
    $display("timeout done");
    wd_disable = 1'b1;
    repeat (3 * TO) begin
      cyc(1);
      chk(sys_reset, 1'b0);
    end
    wd_disable = 1'b0;
    wait_fire(n);
    chk(n >= TO && n <= TO + 8, 1'b1);
    pulse(n);
    supply_good = 1'b0;
    cyc(6);
    chk(wake, 1'b1);
    chk(mem_wr_n, 1'b1);
    $display("fault done");
  endtask
  initial begin
    cyc(3);
    sys_rst = 1'b0;
    t_main();
    test_done();
  end
endmodule
bind wdog_supervisor wdog_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .PULSE_CYC(PULSE_CYC)) i_chk (.*);
